/* File: hdl/drv_cfg_pkg.sv */
// Constants, field layouts and carrier types for the output driver configuration bank
package drv_cfg_pkg;

  localparam int unsigned DATA_W  = 16;
  localparam int unsigned ADDR_W  = 3;
  localparam int unsigned PWR_W   = 3;
  localparam int unsigned VCM_W   = 2;
  localparam int unsigned PRE_W   = 2;
  localparam int unsigned FMT_W   = 2;
  localparam int unsigned N_MAIN  = 4;

  // Register indices, one 32-bit word each on the bus
  localparam logic [ADDR_W-1:0] IDX_ENA_PWR  = 3'h4;
  localparam logic [ADDR_W-1:0] IDX_PWR_LVL  = 3'h5;
  localparam logic [ADDR_W-1:0] IDX_PULSE_CM = 3'h6;
  localparam logic [ADDR_W-1:0] IDX_LOGIC    = 3'h7;
  localparam logic [ADDR_W-1:0] IDX_FMT      = 3'h0;

  // Reset values
  localparam logic [DATA_W-1:0] RST_ENA_PWR  = 16'h36FF;
  localparam logic [DATA_W-1:0] RST_PWR_LVL  = 16'h4936;
  localparam logic [DATA_W-1:0] RST_PULSE_CM = 16'hB6DC;
  localparam logic [DATA_W-1:0] RST_LOGIC    = 16'h0001;
  localparam logic [DATA_W-1:0] RST_FMT      = 16'h0000;

  // Writable-bit masks; reserved bits stay zero
  localparam logic [DATA_W-1:0] WMASK_ENA_PWR  = 16'h3FFF;
  localparam logic [DATA_W-1:0] WMASK_PWR_LVL  = 16'h7FFF;
  localparam logic [DATA_W-1:0] WMASK_PULSE_CM = 16'hFFFF;
  localparam logic [DATA_W-1:0] WMASK_LOGIC    = 16'h7FFF;
  localparam logic [DATA_W-1:0] WMASK_FMT      = 16'h0003;

  // Field positions (low bit)
  localparam int unsigned POS_MAIN1_PWR   = 11;
  localparam int unsigned POS_MAIN0_PWR   = 8;
  localparam int unsigned POS_PULSE_EN    = 4;
  localparam int unsigned POS_MAIN_EN     = 0;
  localparam int unsigned POS_PULSE2_PWR  = 12;
  localparam int unsigned POS_PULSE1_PWR  = 9;
  localparam int unsigned POS_PULSE0_PWR  = 6;
  localparam int unsigned POS_MAIN3_PWR   = 3;
  localparam int unsigned POS_MAIN2_PWR   = 0;
  localparam int unsigned POS_LOGIC_EN    = 15;
  localparam int unsigned POS_PULSE_CM0   = 3;
  localparam int unsigned POS_PULSE3_PWR  = 0;
  localparam int unsigned POS_LP_CM       = 13;
  localparam int unsigned POS_LO_CM       = 11;
  localparam int unsigned POS_LP_PRE      = 9;
  localparam int unsigned POS_LO_PRE      = 7;
  localparam int unsigned POS_LP_PWR      = 4;
  localparam int unsigned POS_LO_PWR      = 1;
  localparam int unsigned POS_LP_EN       = 0;

  // Logic clock driver format codes
  typedef enum logic [FMT_W-1:0] {
    FMT_LVDS = 2'h0,
    FMT_RSV1 = 2'h1,
    FMT_CML  = 2'h2,
    FMT_RSV3 = 2'h3
  } drv_format_t;

  // Effective drive settings presented to the analog output stages
  typedef struct packed {
    logic [N_MAIN-1:0]          main_enable;
    logic [N_MAIN-1:0]          pulse_enable;
    logic [N_MAIN*PWR_W-1:0]    main_power;
    logic [N_MAIN*PWR_W-1:0]    pulse_power;
    logic [N_MAIN*PWR_W-1:0]    pulse_common_mode;
    logic                       logic_out_enable;
    logic                       logic_pulse_enable;
    logic [VCM_W-1:0]           logic_out_common_mode;
    logic [VCM_W-1:0]           logic_pulse_common_mode;
    logic [PRE_W-1:0]           logic_out_predriver_power;
    logic [PRE_W-1:0]           logic_pulse_predriver_power;
    logic [PWR_W-1:0]           logic_out_power;
    logic [PWR_W-1:0]           logic_pulse_power;
    logic                       logic_out_lvds;
    logic                       logic_out_cml;
  } drv_settings_t;

  // One bus request as decoded by the slave
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] idx;
    logic [DATA_W-1:0] wdata;
    logic [1:0]        be;
  } bus_req_t;

endpackage : drv_cfg_pkg

/* File: hdl/cfg_word_reg.sv */
// One configuration word with reset value, write mask and byte enables
`timescale 1ns/1ps
module cfg_word_reg #(
  parameter int unsigned               W     = 16,
  parameter logic [W-1:0]              RST   = '0,
  parameter logic [W-1:0]              WMASK = '1
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         reset,
  // Write side
  input  wire logic         wr_en,
  input  wire logic [W/8-1:0] be,
  input  wire logic [W-1:0] wdata,
  // Stored value
  output logic [W-1:0]      value
);

  logic [W-1:0] word_r;
  logic [W-1:0] word_nxt;
  logic [W-1:0] lane_mask;

  initial begin
    if (W % 8 != 0) $error("cfg_word_reg: width must be whole bytes");
  end

  always_comb begin
    for (int i = 0; i < W; i++) begin
      lane_mask[i] = be[i/8];
    end
    word_nxt = word_r;
    if (wr_en) begin
      word_nxt = (word_r & ~(lane_mask & WMASK)) | (wdata & lane_mask & WMASK);
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      word_r <= RST;
    end else begin
      word_r <= word_nxt;
    end
  end

  assign value = word_r;

endmodule : cfg_word_reg

/* File: hdl/drv_settings_map.sv */
// Splits stored words into effective driver settings, gating format-dependent fields
`timescale 1ns/1ps
module drv_settings_map (
  // Stored words
  input  wire logic [15:0]            ena_pwr,
  input  wire logic [15:0]            pwr_lvl,
  input  wire logic [15:0]            pulse_cm,
  input  wire logic [15:0]            logic_word,
  input  wire logic [1:0]             out_format,
  // Effective settings
  output drv_cfg_pkg::drv_settings_t  settings
);

  localparam int unsigned PW = drv_cfg_pkg::PWR_W;
  localparam int unsigned VW = drv_cfg_pkg::VCM_W;

  logic lvds;
  logic cml;

  assign lvds = (out_format == drv_cfg_pkg::FMT_LVDS);
  assign cml  = (out_format == drv_cfg_pkg::FMT_CML);

  always_comb begin
    settings = '0;
    settings.main_enable  = ena_pwr[drv_cfg_pkg::POS_MAIN_EN +: drv_cfg_pkg::N_MAIN];
    settings.pulse_enable = ena_pwr[drv_cfg_pkg::POS_PULSE_EN +: drv_cfg_pkg::N_MAIN];
    settings.main_power[0*PW +: PW] = ena_pwr[drv_cfg_pkg::POS_MAIN0_PWR +: PW];
    settings.main_power[1*PW +: PW] = ena_pwr[drv_cfg_pkg::POS_MAIN1_PWR +: PW];
    settings.main_power[2*PW +: PW] = pwr_lvl[drv_cfg_pkg::POS_MAIN2_PWR +: PW];
    settings.main_power[3*PW +: PW] = pwr_lvl[drv_cfg_pkg::POS_MAIN3_PWR +: PW];
    settings.pulse_power[0*PW +: PW] = pwr_lvl[drv_cfg_pkg::POS_PULSE0_PWR +: PW];
    settings.pulse_power[1*PW +: PW] = pwr_lvl[drv_cfg_pkg::POS_PULSE1_PWR +: PW];
    settings.pulse_power[2*PW +: PW] = pwr_lvl[drv_cfg_pkg::POS_PULSE2_PWR +: PW];
    settings.pulse_power[3*PW +: PW] = pulse_cm[drv_cfg_pkg::POS_PULSE3_PWR +: PW];
    settings.pulse_common_mode = pulse_cm[drv_cfg_pkg::POS_PULSE_CM0 +: drv_cfg_pkg::N_MAIN*PW];
    settings.logic_out_enable   = pulse_cm[drv_cfg_pkg::POS_LOGIC_EN];
    settings.logic_pulse_enable = logic_word[drv_cfg_pkg::POS_LP_EN];
    // LVDS-only common mode; pulse format is outside this bank, assumed LVDS
    settings.logic_pulse_common_mode = logic_word[drv_cfg_pkg::POS_LP_CM +: VW];
    settings.logic_out_common_mode = lvds ? logic_word[drv_cfg_pkg::POS_LO_CM +: VW] : '0;
    settings.logic_pulse_predriver_power = logic_word[drv_cfg_pkg::POS_LP_PRE +: drv_cfg_pkg::PRE_W];
    settings.logic_out_predriver_power = logic_word[drv_cfg_pkg::POS_LO_PRE +: drv_cfg_pkg::PRE_W];
    settings.logic_pulse_power = logic_word[drv_cfg_pkg::POS_LP_PWR +: PW];
    settings.logic_out_power = cml ? logic_word[drv_cfg_pkg::POS_LO_PWR +: PW] : '0;
    settings.logic_out_lvds  = lvds;
    settings.logic_out_cml   = cml;
  end

endmodule : drv_settings_map

/* File: hdl/output_driver_config_regs.sv */
// Output driver configuration bank behind an Avalon-MM slave
//
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/1ps
module output_driver_config_regs (
  // Clock and reset
  input  wire logic                        ref_clk,
  input  wire logic                        reset,
  // Avalon-MM slave
  input  wire logic [4:0]                  avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [31:0]                 avs_writedata,
  input  wire logic [3:0]                  avs_byteenable,
  output logic [31:0]                      avs_readdata,
  output logic                             avs_waitrequest,
  output logic [1:0]                       avs_response,
  // Driver settings
  output drv_cfg_pkg::drv_settings_t       settings
);

  localparam int unsigned DW = drv_cfg_pkg::DATA_W;

  // Slave states, Gray along idle -> answer
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_ANS  = 2'h1,
    ST_DONE = 2'h3
  } bus_state_t;

  bus_state_t              state_r;
  bus_state_t              state_nxt;
  logic [31:0]             rdata_r;
  logic [31:0]             rdata_nxt;
  logic [1:0]              resp_r;
  logic [1:0]              resp_nxt;
  logic                    wait_r;
  logic                    wait_nxt;
  drv_cfg_pkg::bus_req_t   req;
  logic                    hit;
  logic [DW-1:0]           rd_word;
  logic                    take;
  logic [4:0]              wr_sel;
  logic [DW-1:0]           word_q [5];
  drv_cfg_pkg::drv_settings_t settings_c;
  drv_cfg_pkg::drv_settings_t settings_r;

  localparam logic [DW-1:0] RSTS [5] = '{drv_cfg_pkg::RST_ENA_PWR, drv_cfg_pkg::RST_PWR_LVL,
                                         drv_cfg_pkg::RST_PULSE_CM, drv_cfg_pkg::RST_LOGIC,
                                         drv_cfg_pkg::RST_FMT};
  localparam logic [DW-1:0] MASKS [5] = '{drv_cfg_pkg::WMASK_ENA_PWR,
                                          drv_cfg_pkg::WMASK_PWR_LVL,
                                          drv_cfg_pkg::WMASK_PULSE_CM,
                                          drv_cfg_pkg::WMASK_LOGIC,
                                          drv_cfg_pkg::WMASK_FMT};
  localparam logic [drv_cfg_pkg::ADDR_W-1:0] IDXS [5] = '{drv_cfg_pkg::IDX_ENA_PWR,
                                                         drv_cfg_pkg::IDX_PWR_LVL,
                                                         drv_cfg_pkg::IDX_PULSE_CM,
                                                         drv_cfg_pkg::IDX_LOGIC,
                                                         drv_cfg_pkg::IDX_FMT};

  // Word address: byte address / 4, so avs_address carries the index
  always_comb begin
    req.wr    = avs_write;
    req.rd    = avs_read;
    req.idx   = avs_address[drv_cfg_pkg::ADDR_W-1:0];
    req.wdata = avs_writedata[DW-1:0];
    req.be    = avs_byteenable[1:0];
  end

  // Request accepted once, in the idle state
  assign take = (state_r == ST_IDLE) && (req.wr || req.rd);

  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_word
      assign wr_sel[g] = take && req.wr &&
                         (avs_address[4:3] == 2'h0) && (req.idx == IDXS[g]);
      cfg_word_reg #(
        .W     (DW),
        .RST   (RSTS[g]),
        .WMASK (MASKS[g])
      ) u_word (
        .ref_clk (ref_clk),
        .reset   (reset),
        .wr_en   (wr_sel[g]),
        .be      (req.be),
        .wdata   (req.wdata),
        .value   (word_q[g])
      );
    end
  endgenerate

  // Read decode; reserved bits are stored as zero
  always_comb begin
    hit     = 1'b1;
    rd_word = '0;
    if (avs_address[4:3] != 2'h0) begin
      hit = 1'b0;
    end else if (req.idx == drv_cfg_pkg::IDX_ENA_PWR) begin
      rd_word = word_q[0];
    end else if (req.idx == drv_cfg_pkg::IDX_PWR_LVL) begin
      rd_word = word_q[1];
    end else if (req.idx == drv_cfg_pkg::IDX_PULSE_CM) begin
      rd_word = word_q[2];
    end else if (req.idx == drv_cfg_pkg::IDX_LOGIC) begin
      rd_word = word_q[3];
    end else if (req.idx == drv_cfg_pkg::IDX_FMT) begin
      rd_word = word_q[4];
    end else begin
      hit = 1'b0;
    end
  end

  // Fixed two-cycle answer keeps read data a clean flop output
  always_comb begin
    state_nxt = state_r;
    rdata_nxt = rdata_r;
    resp_nxt  = resp_r;
    wait_nxt  = 1'b1;
    case (state_r)
      ST_IDLE: begin
        if (take) begin
          state_nxt = ST_ANS;
          wait_nxt  = 1'b0;
          rdata_nxt = {16'h0000, rd_word};
          resp_nxt  = hit ? 2'h0 : 2'h3;
        end
      end
      ST_ANS: begin
        state_nxt = ST_DONE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_r <= ST_IDLE;
      rdata_r <= 32'h0000_0000;
      resp_r  <= 2'h0;
      wait_r  <= 1'b1;
    end else begin
      state_r <= state_nxt;
      rdata_r <= rdata_nxt;
      resp_r  <= resp_nxt;
      wait_r  <= wait_nxt;
    end
  end

  drv_settings_map u_map (
    .ena_pwr    (word_q[0]),
    .pwr_lvl    (word_q[1]),
    .pulse_cm   (word_q[2]),
    .logic_word (word_q[3]),
    .out_format (word_q[4][drv_cfg_pkg::FMT_W-1:0]),
    .settings   (settings_c)
  );

  // Settings registered so outputs come from flops
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      settings_r <= '0;
    end else begin
      settings_r <= settings_c;
    end
  end

  assign avs_readdata    = rdata_r;
  assign avs_waitrequest = wait_r;
  assign avs_response    = resp_r;
  assign settings        = settings_r;

  // reset power of main output 0
  chk_main_pwr_reset: assert property (@(posedge ref_clk)
    $fell(reset) |-> word_q[0][drv_cfg_pkg::POS_MAIN0_PWR +: 3] == 3'h6)
    else $error("main power reset wrong");
  // main 3 power follows register
  // Settings still read all zero one edge after release
  chk_main3_pwr: assert property (@(posedge ref_clk) disable iff (reset)
    !$past(reset) |->
    settings.main_power[9 +: 3] == $past(word_q[1][drv_cfg_pkg::POS_MAIN3_PWR +: 3]))
    else $error("main 3 power mismatch");
  chk_pulse_en: assert property (@(posedge ref_clk) disable iff (reset)
    !$past(reset) |-> settings.pulse_enable == $past(word_q[0][7:4]))
    else $error("pulse enable mismatch");
  chk_main_en: assert property (@(posedge ref_clk) disable iff (reset)
    !$past(reset) |-> settings.main_enable == $past(word_q[0][3:0]))
    else $error("main enable mismatch");
  chk_cm_reset: assert property (@(posedge ref_clk)
    $fell(reset) |-> word_q[2][14:3] == 12'h6DB)
    else $error("common mode reset wrong");
  chk_lo_cm_gate: assert property (@(posedge ref_clk) disable iff (reset)
    !settings.logic_out_lvds |-> settings.logic_out_common_mode == 2'h0)
    else $error("common mode leaks outside LVDS");
  chk_lo_pwr_gate: assert property (@(posedge ref_clk) disable iff (reset)
    !settings.logic_out_cml |-> settings.logic_out_power == 3'h0)
    else $error("power leaks outside CML");
  // full write to the logic word is stored by the answer cycle
  sequence s_write_logic;
    take && req.wr && hit && req.idx == drv_cfg_pkg::IDX_LOGIC && req.be == 2'h3;
  endsequence
  chk_write_kept: assert property (@(posedge ref_clk) disable iff (reset)
    s_write_logic |=> word_q[3] == ($past(req.wdata) & drv_cfg_pkg::WMASK_LOGIC))
    else $error("written value not kept");
  chk_bus_answer: assert property (@(posedge ref_clk) disable iff (reset)
    take |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer timing wrong");

endmodule : output_driver_config_regs

/* File: dv/tb_output_driver_config_regs.sv */
// Self-checking bench for the output driver configuration bank
`timescale 1ns/1ps

`define CHK(nm, ex, gt) \
  begin \
    n_compared++; \
    if ((gt) !== (ex)) begin \
      n_errors++; \
      $display("unexpected %s expected %0h seen %0h", nm, ex, gt); \
    end \
  end

module tb_output_driver_config_regs;
  logic                       ref_clk;
  logic                       reset;
  logic [4:0]                 avs_address;
  logic                       avs_read;
  logic                       avs_write;
  logic [31:0]                avs_writedata;
  logic [3:0]                 avs_byteenable;
  logic [31:0]                avs_readdata;
  logic                       avs_waitrequest;
  logic [1:0]                 avs_response;
  drv_cfg_pkg::drv_settings_t settings;
  int                         n_errors;
  int                         n_compared;
  logic [15:0]                mem [0:7];
  logic [15:0]                wmask [0:7];
  logic [4:0]                 mapped_list [0:4] = '{5'h00, 5'h04, 5'h05, 5'h06, 5'h07};
  logic [15:0]                pats [0:4] = '{16'hFFFF, 16'h0000, 16'hAAAA, 16'h5555, 16'h1234};
  logic [4:0]                 bad_list [0:4] = '{5'h01, 5'h02, 5'h03, 5'h0C, 5'h17};

  output_driver_config_regs DUT (
    .ref_clk         (ref_clk),
    .reset           (reset),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_byteenable  (avs_byteenable),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .avs_response    (avs_response),
    .settings        (settings)
  );

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  function automatic logic is_mapped(input logic [4:0] a);
    return (a[4:3] == 2'b00) && ((a[2:0] == 3'h0) || a[2]);
  endfunction : is_mapped

  task automatic model_reset();
    mem = '{default: 16'h0000};
    wmask = '{default: 16'h0000};
    mem[4] = drv_cfg_pkg::RST_ENA_PWR;
    mem[5] = drv_cfg_pkg::RST_PWR_LVL;
    mem[6] = drv_cfg_pkg::RST_PULSE_CM;
    mem[7] = drv_cfg_pkg::RST_LOGIC;
    mem[0] = drv_cfg_pkg::RST_FMT;
    wmask[4] = drv_cfg_pkg::WMASK_ENA_PWR;
    wmask[5] = drv_cfg_pkg::WMASK_PWR_LVL;
    wmask[6] = drv_cfg_pkg::WMASK_PULSE_CM;
    wmask[7] = drv_cfg_pkg::WMASK_LOGIC;
    wmask[0] = drv_cfg_pkg::WMASK_FMT;
  endtask : model_reset

  // One Avalon cycle; held until waitrequest is seen low, then released
  task automatic access(input logic wr, input logic [4:0] a, input logic [15:0] d,
                        input logic [1:0] be, output logic [31:0] rd, output logic [1:0] rs);
    int k;
    k = 0;
    avs_address    <= a;
    avs_write      <= wr;
    avs_read       <= ~wr;
    avs_writedata  <= {16'h0000, d};
    avs_byteenable <= {2'b11, be};
    do begin
      @(posedge ref_clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 64);
    `CHK("answer in time", 1'b1, k < 64)
    rd = avs_readdata;
    rs = avs_response;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    // Edge between requests so no signal is driven twice in one step
    @(posedge ref_clk);
  endtask : access

  task automatic bus_wr(input logic [4:0] a, input logic [15:0] d, input logic [1:0] be);
    logic [31:0] rd;
    logic [1:0]  rs;
    logic [15:0] lm;
    access(1'b1, a, is_mapped(a) ? (d & wmask[a[2:0]]) : d, be, rd, rs);
    lm = {{8{be[1]}}, {8{be[0]}}} & wmask[a[2:0]];
    if (is_mapped(a)) mem[a[2:0]] = (mem[a[2:0]] & ~lm) | (d & lm);
    `CHK("write response", is_mapped(a) ? 2'b00 : 2'b11, rs)
  endtask : bus_wr

  task automatic bus_rd(input logic [4:0] a);
    logic [31:0] rd;
    logic [1:0]  rs;
    access(1'b0, a, 16'h0000, 2'b11, rd, rs);
    `CHK("read data", is_mapped(a) ? {16'h0000, mem[a[2:0]]} : 32'h00000000, rd)
    `CHK("read response", is_mapped(a) ? 2'b00 : 2'b11, rs)
  endtask : bus_rd

  function automatic drv_cfg_pkg::drv_settings_t exp_set();
    drv_cfg_pkg::drv_settings_t s;
    logic [15:0] m4, m5, m6, m7;
    m4 = mem[4];
    m5 = mem[5];
    m6 = mem[6];
    m7 = mem[7];
    s.main_enable                 = m4[3:0];
    s.pulse_enable                = m4[7:4];
    s.main_power                  = {m5[5:3], m5[2:0], m4[13:11], m4[10:8]};
    s.pulse_power                 = {m6[2:0], m5[14:12], m5[11:9], m5[8:6]};
    s.pulse_common_mode           = {m6[14:12], m6[11:9], m6[8:6], m6[5:3]};
    s.logic_out_enable            = m6[15];
    s.logic_pulse_enable          = m7[0];
    s.logic_out_lvds              = (mem[0][1:0] == 2'h0);
    s.logic_out_cml               = (mem[0][1:0] == 2'h2);
    s.logic_out_common_mode       = s.logic_out_lvds ? m7[12:11] : 2'h0;
    s.logic_pulse_common_mode     = m7[14:13];
    s.logic_out_predriver_power   = m7[8:7];
    s.logic_pulse_predriver_power = m7[10:9];
    s.logic_out_power             = s.logic_out_cml ? m7[3:1] : 3'h0;
    s.logic_pulse_power           = m7[6:4];
    return s;
  endfunction : exp_set

  task automatic check_all();
    foreach (mapped_list[i]) bus_rd(mapped_list[i]);
    `CHK("settings", exp_set(), settings)
  endtask : check_all

  task automatic do_reset();
    reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    `CHK("settings in reset", '0, settings)
    `CHK("waitrequest in reset", 1'b1, avs_waitrequest)
    reset <= 1'b0;
    model_reset();
    repeat (2) @(posedge ref_clk);
  endtask : do_reset

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    wrap_up();
  end

  initial begin
    n_errors = 0;
    n_compared = 0;
    reset = 1'b1;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'h0;
    @(posedge ref_clk);
    do_reset();
    // Reset image of every word and of the drive settings
    check_all();
    // Patterns through every word, written pre-masked so reserved bits are sent as zero
    // power and common mode written together
    foreach (pats[p]) begin
      foreach (mapped_list[i]) bus_wr(mapped_list[i], pats[p] ^ {11'h000, mapped_list[i]}, 2'b11);
      check_all();
    end
    // Lanes are independent
    bus_wr(5'h05, 16'hFFFF, 2'b01);
    check_all();
    bus_wr(5'h05, 16'h0000, 2'b10);
    check_all();
    bus_wr(5'h06, 16'h0000, 2'b00);
    check_all();
    // Every format code tried: logic clock common mode passes only in LVDS, power only in CML
    bus_wr(5'h07, 16'h7FFE, 2'b11);
    for (int f = 0; f < 4; f++) begin
      bus_wr(5'h00, 16'(f), 2'b11);
      check_all();
    end
    // Unmapped places: decode error, read zero, nothing stored
    foreach (bad_list[i]) begin
      bus_wr(bad_list[i], 16'hFFFF, 2'b11);
      bus_rd(bad_list[i]);
    end
    check_all();
    // Second reset in mid-run restores the documented image
    do_reset();
    check_all();
    wrap_up();
  end
endmodule : tb_output_driver_config_regs
